// ---- include/pesel_pkg.sv ----
// Purpose: constants and carrier types for the peripheral enable / pin share block
// Assumes: 32-bit config bus, byte addresses as printed
// Notes:   pad enables are active low (low = this side drives the pad)
`default_nettype none
package pesel_pkg;
  // register addresses
  localparam logic [31:0] PESEL_CFG_ADDR  = 32'h01b3_f000;
  localparam logic [31:0] PESEL_LOCK_ADDR = 32'h01b3_f018;
  localparam logic [31:0] PESEL_LOCK_KEY  = 32'h10c0_010c;
  // field positions in peripheral_enable_select
  localparam int PESEL_AUDIO_BIT = 0;
  localparam int PESEL_SER0_BIT  = 1;
  localparam int PESEL_SER1_BIT  = 2;
  localparam int PESEL_TWI_BIT   = 3;
  localparam int PESEL_VP0_BIT   = 4;
  localparam int PESEL_VP1_BIT   = 5;
  localparam int PESEL_VP2_BIT   = 6;
  localparam int PESEL_CFG_W     = 7;
  // reset values: both serial ports own their lower pins, all other enables off, register locked
  localparam logic [6:0]  PESEL_CFG_RST  = 7'h06;
  localparam logic        PESEL_LOCK_RST = 1'h1;
  // shared pad group widths: data 19:12 and data 8:2
  localparam int PESEL_UP_W = 8;
  localparam int PESEL_LO_W = 7;
  // upper pad group, output value and active-low enable
  typedef struct packed {
    logic [PESEL_UP_W-1:0] o;
    logic [PESEL_UP_W-1:0] oe_b;
  } pesel_up_t;
  // lower pad group
  typedef struct packed {
    logic [PESEL_LO_W-1:0] o;
    logic [PESEL_LO_W-1:0] oe_b;
  } pesel_lo_t;
endpackage : pesel_pkg
`default_nettype wire

// ---- core/pesel_pad_share.sv ----
// Purpose: pad output steering for one video port's shared data lines
// Assumes: selects come from registered configuration bits
// Notes:   pad inputs reach every owner straight from the pad ring, not through here
`default_nettype none
module pesel_pad_share
  import pesel_pkg::*;
(
  // selects
  input  wire logic vid_en,   // video port powered
  input  wire logic ser_sel,  // serial port owns lower pads
  input  wire logic aud_sel,  // audio port owns upper pads
  // upper group sources
  input  wire pesel_up_t vid_up,
  input  wire pesel_up_t aud_up,
  // lower group sources
  input  wire pesel_lo_t vid_lo,
  input  wire pesel_lo_t ser_lo,
  // pads
  output pesel_up_t pad_up,
  output pesel_lo_t pad_lo
);
  ////////////////////////////////////////////////////////////////////////////////
  // steering; an unowned group is released (all enables high) so nothing fights
  always_comb begin
    if (aud_sel) begin
      pad_up = aud_up;
    end else if (vid_en) begin
      pad_up = vid_up;
    end else begin
      pad_up = '{o: '0, oe_b: '1};
    end
    if (ser_sel) begin
      pad_lo = ser_lo;
    end else if (vid_en) begin
      pad_lo = vid_lo;
    end else begin
      pad_lo = '{o: '0, oe_b: '1};
    end
  end
endmodule // pesel_pad_share
`default_nettype wire

// ---- core/pesel_top.sv ----
// Purpose: peripheral enable register with key lock and shared pad steering
// Assumes: single-cycle write/read strobes on the config bus, clk_sys domain
// Notes:   read data returns one cycle after the read strobe, with rvalid
`default_nettype none
module pesel_top
  import pesel_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // config bus
  input  wire logic [31:0] cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // peripheral enables
  output logic             video_port_two_enable,
  output logic             video_port_one_enable,
  output logic             video_port_zero_enable,
  output logic             two_wire_port_enable,
  output logic             serial_port_one_select,
  output logic             serial_port_zero_select,
  output logic             audio_port_select,
  // first video port pads and their alternates
  input  wire pesel_up_t   vid0_up,
  input  wire pesel_lo_t   vid0_lo,
  input  wire pesel_up_t   aud_ctl_up,
  input  wire pesel_lo_t   ser0_lo,
  output pesel_up_t        pad0_up,
  output pesel_lo_t        pad0_lo,
  // second video port pads and their alternates
  input  wire pesel_up_t   vid1_up,
  input  wire pesel_lo_t   vid1_lo,
  input  wire pesel_up_t   aud_data_up,
  input  wire pesel_lo_t   ser1_lo,
  output pesel_up_t        pad1_up,
  output pesel_lo_t        pad1_lo
);
  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [PESEL_CFG_W-1:0] cfg_r,    cfg_nxt;     // peripheral_enable_select
  logic                   locked_r, locked_nxt;  // config_locked_flag
  logic [31:0]            rdata_r,  rdata_nxt;   // read data holding flop
  logic                   rvld_r,   rvld_nxt;    // read answer strobe
  logic                   wr_cfg;                // write hits config register
  logic                   wr_lock;               // write hits lock register

  // address match, shared by read and write decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
    hit = (a == base);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register next state
  always_comb begin
    wr_cfg     = cfg_wr && hit(cfg_addr, PESEL_CFG_ADDR);
    wr_lock    = cfg_wr && hit(cfg_addr, PESEL_LOCK_ADDR);
    cfg_nxt    = cfg_r;
    locked_nxt = locked_r;
    rdata_nxt  = rdata_r;
    rvld_nxt   = 1'b0;
    if (wr_cfg) begin
      if (!locked_r) begin
        cfg_nxt = cfg_wdata[PESEL_CFG_W-1:0];
      end
      locked_nxt = 1'b1;
    end else if (wr_lock && cfg_wdata == PESEL_LOCK_KEY) begin
      locked_nxt = 1'b0;
    end
    if (cfg_rd) begin
      rvld_nxt = 1'b1;
      if (hit(cfg_addr, PESEL_CFG_ADDR)) begin
        rdata_nxt = {25'h0, cfg_r};
      end else if (hit(cfg_addr, PESEL_LOCK_ADDR)) begin
        rdata_nxt = {31'h0, locked_r};
      end else begin
        rdata_nxt = 32'h0;                             // unmapped reads zero
      end
    end
  end

  // registers; ce low freezes everything except the synchronous reset, which still loads the reset values
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_r    <= PESEL_CFG_RST;
      locked_r <= PESEL_LOCK_RST;
      rdata_r  <= 32'h0;
      rvld_r   <= 1'b0;
    end else if (ce) begin
      cfg_r    <= cfg_nxt;
      locked_r <= locked_nxt;
      rdata_r  <= rdata_nxt;
      rvld_r   <= rvld_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the registers, rvalid gated by ce; a clear bit powers the module down
  assign cfg_rdata               = rdata_r;
  assign cfg_rvalid              = rvld_r && ce;
  assign video_port_two_enable   = cfg_r[PESEL_VP2_BIT];
  assign video_port_one_enable   = cfg_r[PESEL_VP1_BIT];
  assign video_port_zero_enable  = cfg_r[PESEL_VP0_BIT];
  assign two_wire_port_enable    = cfg_r[PESEL_TWI_BIT];
  assign serial_port_one_select  = cfg_r[PESEL_SER1_BIT];
  assign serial_port_zero_select = cfg_r[PESEL_SER0_BIT];
  assign audio_port_select       = cfg_r[PESEL_AUDIO_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // first video port: upper pads carry audio clocks/syncs/mutes
  pesel_pad_share u_share0 (
    .vid_en  (cfg_r[PESEL_VP0_BIT]),
    .ser_sel (cfg_r[PESEL_SER0_BIT]),
    .aud_sel (cfg_r[PESEL_AUDIO_BIT]),
    .vid_up  (vid0_up),
    .aud_up  (aud_ctl_up),
    .vid_lo  (vid0_lo),
    .ser_lo  (ser0_lo),
    .pad_up  (pad0_up),
    .pad_lo  (pad0_lo)
  );

  // second video port: upper pads carry audio serial data 7:0
  pesel_pad_share u_share1 (
    .vid_en  (cfg_r[PESEL_VP1_BIT]),
    .ser_sel (cfg_r[PESEL_SER1_BIT]),
    .aud_sel (cfg_r[PESEL_AUDIO_BIT]),
    .vid_up  (vid1_up),
    .aud_up  (aud_data_up),
    .vid_lo  (vid1_lo),
    .ser_lo  (ser1_lo),
    .pad_up  (pad1_up),
    .pad_lo  (pad1_lo)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks: lock behaviour and read view
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && cfg_rd && cfg_addr == PESEL_CFG_ADDR) |=> cfg_rdata[31:7] == 25'h0)
    else $error("reserved bits read nonzero");
  a_locked_ignore: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && locked_r && cfg_wr && cfg_addr == PESEL_CFG_ADDR) |=> $stable(cfg_r))
    else $error("locked register changed");
  a_write_relocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && cfg_wr && cfg_addr == PESEL_CFG_ADDR) |=> locked_r)
    else $error("config write left register unlocked");
  a_key_unlocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && cfg_wr && cfg_addr == PESEL_LOCK_ADDR && cfg_wdata == PESEL_LOCK_KEY)
      |=> !locked_r)
    else $error("key did not unlock");
  a_bad_key_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && locked_r && wr_lock && cfg_wdata != PESEL_LOCK_KEY) |=> locked_r)
    else $error("wrong key unlocked the register");
  // checks: every enable follows an accepted write
  a_vp2_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && cfg_wr && cfg_addr == PESEL_CFG_ADDR)
      |=> video_port_two_enable == $past(cfg_wdata[6])
       && two_wire_port_enable == $past(cfg_wdata[3]))
    else $error("enable bits not taken from write");
  a_vp1_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> video_port_one_enable == $past(cfg_wdata[PESEL_VP1_BIT]))
    else $error("second video enable not taken from write");
  a_vp0_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> video_port_zero_enable == $past(cfg_wdata[PESEL_VP0_BIT]))
    else $error("first video enable not taken from write");
  a_twi_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> two_wire_port_enable == $past(cfg_wdata[PESEL_TWI_BIT]))
    else $error("two-wire enable not taken from write");
  a_ser1_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> serial_port_one_select == $past(cfg_wdata[PESEL_SER1_BIT]))
    else $error("serial one select not taken from write");
  a_ser0_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> serial_port_zero_select == $past(cfg_wdata[PESEL_SER0_BIT]))
    else $error("serial zero select not taken from write");
  a_audio_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ce && !locked_r && wr_cfg) |=> audio_port_select == $past(cfg_wdata[PESEL_AUDIO_BIT]))
    else $error("audio select not taken from write");
  // checks: pad ownership
  a_audio_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
    audio_port_select |-> pad1_up == aud_data_up && pad0_up == aud_ctl_up)
    else $error("audio does not own upper pads");
  a_video_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!audio_port_select && video_port_one_enable) |-> pad1_up == vid1_up)
    else $error("video upper pads not routed");
  a_video0_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!audio_port_select && video_port_zero_enable) |-> pad0_up == vid0_up)
    else $error("first video upper pads not routed");
  a_upper_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!audio_port_select && !video_port_one_enable) |-> pad1_up.oe_b == '1)
    else $error("unowned upper pads driven");
  a_serial_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    serial_port_one_select |-> pad1_lo == ser1_lo)
    else $error("serial one does not own lower pads");
  a_video1_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!serial_port_one_select && video_port_one_enable) |-> pad1_lo == vid1_lo)
    else $error("second video lower pads not routed");
  a_serial0_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    serial_port_zero_select |-> pad0_lo == ser0_lo)
    else $error("serial zero does not own lower pads");
  a_video_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!serial_port_zero_select && video_port_zero_enable) |-> pad0_lo == vid0_lo)
    else $error("first video lower pads not routed");
  a_lower_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!serial_port_zero_select && !video_port_zero_enable) |-> pad0_lo.oe_b == '1)
    else $error("unowned lower pads driven");
endmodule // pesel_top
`default_nettype wire

// ---- testbench/test_pesel_top.sv ----
// Purpose: self-checking bench for the peripheral enable register and its pad steering
// Assumes: strobes driven by non-blocking assignment on the rising edge, ce held high except around one key write
// Notes:   pads are combinational, so they are sampled on the falling edge after a read
`default_nettype none
module test_pesel_top
  import pesel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // distinct source patterns so a wrong owner shows on the pads
  localparam pesel_up_t V0U = {8'h3c, 8'h00};
  localparam pesel_up_t V1U = {8'hc3, 8'h0f};
  localparam pesel_up_t ACU = {8'h5a, 8'h11};
  localparam pesel_up_t ADU = {8'ha5, 8'h22};
  localparam pesel_lo_t V0L = {7'h2b, 7'h00};
  localparam pesel_lo_t V1L = {7'h54, 7'h03};
  localparam pesel_lo_t S0L = {7'h19, 7'h0c};
  localparam pesel_lo_t S1L = {7'h66, 7'h30};
  logic        clk_sys, rst_b, ce, cfg_wr, cfg_rd, cfg_rvalid;  // control and strobes
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, rdat;            // bus words
  wire  [6:0]  en_vec;                                          // enables, bit 6 first
  pesel_up_t   vid0_up, aud_ctl_up, vid1_up, aud_data_up, pad0_up, pad1_up;
  pesel_lo_t   vid0_lo, ser0_lo, vid1_lo, ser1_lo, pad0_lo, pad1_lo;
  int          n_mismatch, checks_done;                         // report counters
  logic [6:0]  tbl [11] = '{7'h00, 7'h01, 7'h06, 7'h08, 7'h10, 7'h12, 7'h24,
                            7'h31, 7'h37, 7'h4c, 7'h7f};        // owner mixes, bar second-port video on both groups
  ////////////////////////////////////////////////////////////////////////////////
  pesel_top u_pesel_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .video_port_two_enable(en_vec[6]), .video_port_one_enable(en_vec[5]),
    .video_port_zero_enable(en_vec[4]), .two_wire_port_enable(en_vec[3]),
    .serial_port_one_select(en_vec[2]), .serial_port_zero_select(en_vec[1]),
    .audio_port_select(en_vec[0]), .vid0_up(vid0_up), .vid0_lo(vid0_lo),
    .aud_ctl_up(aud_ctl_up), .ser0_lo(ser0_lo), .pad0_up(pad0_up), .pad0_lo(pad0_lo),
    .vid1_up(vid1_up), .vid1_lo(vid1_lo), .aud_data_up(aud_data_up), .ser1_lo(ser1_lo),
    .pad1_up(pad1_up), .pad1_lo(pad1_lo));
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // verdict, the single place the run ends
  task automatic test_done();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1; cfg_addr <= a; cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  // read strobe, then wait a bounded time for the answer pulse
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    int i;
    bit seen;
    seen = 1'b0;
    @(posedge clk_sys);
    cfg_rd <= 1'b1; cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    for (i = 0; i < 4 && !seen; i++) begin
      @(negedge clk_sys);
      if (cfg_rvalid === 1'b1) begin
        seen = 1'b1;
        rdat = cfg_rdata;
      end
    end
    if (!seen) begin
      n_mismatch++;
      $display("CHECK FAILED %s rvalid expected 1 seen 0", nm);
      test_done();
    end else begin
      chk(nm, e, rdat);
    end
  endtask
  // expected drive of one port: audio then video on the upper group, serial then video on the lower, else released
  function automatic logic [29:0] exp_pad(input logic au, input logic se, input logic ve,
    input pesel_up_t a, input pesel_up_t v, input pesel_lo_t s, input pesel_lo_t l);
    pesel_up_t u;
    pesel_lo_t w;
    u = au ? a : (ve ? v : {8'h00, 8'hff});
    w = se ? s : (ve ? l : {7'h00, 7'h7f});
    return {u, w};
  endfunction
  // enables and both pad groups against a configuration value
  task automatic chk_out(input logic [6:0] c);
    chk("enables", {25'h0, c}, {25'h0, en_vec});
    chk("pads0", {2'h0, exp_pad(c[0], c[1], c[4], ACU, V0U, S0L, V0L)},
        {2'h0, pad0_up, pad0_lo});
    chk("pads1", {2'h0, exp_pad(c[0], c[2], c[5], ADU, V1U, S1L, V1L)},
        {2'h0, pad1_up, pad1_lo});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0; checks_done = 0; rst_b = 1'b0; ce = 1'b1;
    cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 32'h0; cfg_wdata = 32'h0;
    vid0_up = V0U; vid1_up = V1U; aud_ctl_up = ACU; aud_data_up = ADU;
    vid0_lo = V0L; vid1_lo = V1L; ser0_lo = S0L; ser1_lo = S1L;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(PESEL_CFG_ADDR, 32'h06, "cfg reset");
    chk_out(PESEL_CFG_RST);
    rd(PESEL_LOCK_ADDR, 32'h1, "lock reset");
    // locked, wrong key and clock-disabled unlock all leave the value alone
    wr(PESEL_CFG_ADDR, 32'h7f);
    rd(PESEL_CFG_ADDR, 32'h06, "cfg locked");
    wr(PESEL_LOCK_ADDR, PESEL_LOCK_KEY ^ 32'h1);
    wr(PESEL_CFG_ADDR, 32'h7f);
    rd(PESEL_CFG_ADDR, 32'h06, "cfg bad key");
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(PESEL_LOCK_ADDR, PESEL_LOCK_KEY);
    ce <= 1'b1;
    rd(PESEL_LOCK_ADDR, 32'h1, "lock ce low");
    // every owner mix but second-port video on both groups, reserved bits set on each write
    foreach (tbl[k]) begin
      wr(PESEL_LOCK_ADDR, PESEL_LOCK_KEY);
      rd(PESEL_LOCK_ADDR, 32'h0, "lock open");
      wr(PESEL_CFG_ADDR, 32'hffff_ff80 | {25'h0, tbl[k]});
      rd(PESEL_CFG_ADDR, {25'h0, tbl[k]}, "cfg value");
      rd(PESEL_LOCK_ADDR, 32'h1, "lock relocked");
      chk_out(tbl[k]);
    end
    // freshly enabled ports get their settle time before anything else happens
    repeat (128) @(posedge clk_sys);
    // relocked register refuses the next write without a fresh key
    wr(PESEL_CFG_ADDR, 32'h0);
    rd(PESEL_CFG_ADDR, 32'h7f, "cfg after relock");
    rd(PESEL_CFG_ADDR + 32'h10, 32'h0, "unmapped read");
    // reset again mid-run: programmed mix must fall back to the reset mix
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(PESEL_CFG_ADDR, 32'h06, "cfg second reset");
    rd(PESEL_LOCK_ADDR, 32'h1, "lock second reset");
    chk_out(PESEL_CFG_RST);
    test_done();
  end
endmodule // test_pesel_top
`default_nettype wire
